// ### logic/fsc_pkg.sv
// Shared constants for the flash status and configuration readout block
`default_nettype none

package fsc_pkg;

	// ==========================================================
	// Configuration word indices (byte address is four times)
	localparam logic [9:0] IDX_MAKER     = 10'h000;
	localparam logic [9:0] IDX_PART      = 10'h001;
	localparam logic [9:0] IDX_BLKPROT   = 10'h002;
	localparam logic [9:0] IDX_DEVPROT   = 10'h003;
	localparam logic [9:0] IDX_MODE      = 10'h004;
	localparam logic [9:0] IDX_LOCKDIS   = 10'h005;

	// ==========================================================
	// Block-local registers, word indices
	localparam logic [9:0] IDX_STATUS    = 10'h010;
	localparam logic [9:0] IDX_CMD       = 10'h011;
	localparam logic [9:0] IDX_BLKSEL    = 10'h012;
	localparam logic [9:0] IDX_MODEWR    = 10'h013;

	// ==========================================================
	// Status word bit positions
	localparam int unsigned ST_DEVLVL    = 0;
	localparam int unsigned ST_BANK_LO   = 1;
	localparam int unsigned ST_BANK_HI   = 2;
	localparam int unsigned ST_PROTVIOL  = 3;
	localparam int unsigned ST_PROGFAIL  = 4;
	localparam int unsigned ST_ERASEFAIL = 5;
	localparam int unsigned ST_READY     = 7;
	localparam int unsigned ST_PWRSEQ    = 8;

	// ==========================================================
	// Command register bits
	localparam int unsigned CMD_CLR      = 0;
	localparam int unsigned CMD_BLK_WR   = 1;
	localparam int unsigned CMD_BLK_VAL  = 2;
	localparam int unsigned CMD_DEV_WR   = 3;
	localparam int unsigned CMD_DEV_VAL  = 4;
	localparam int unsigned CMD_LOCK_WR  = 5;
	localparam int unsigned CMD_LOCK_VAL = 6;

	// ==========================================================
	// Sticky flag slots
	localparam int unsigned FLG_ERASE    = 0;
	localparam int unsigned FLG_PROG     = 1;
	localparam int unsigned FLG_VIOL     = 2;
	localparam int unsigned FLG_PWR      = 3;
	localparam int unsigned NUM_FLAGS    = 4;

	// ==========================================================
	// Reset values and widths
	localparam logic        DEVPROT_RST  = 1'b0;
	localparam logic        LOCKDIS_RST  = 1'b0;
	localparam logic [15:0] MODE_RST     = 16'h0000;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
	localparam int unsigned HALF_W       = 16;
	localparam int unsigned ADDR_LSB     = 2;

	// ==========================================================
	// Read wait sequencer
	typedef enum logic [1:0]
	{
		RD_IDLE  = 2'b00,
		RD_WAIT  = 2'b01,
		RD_FETCH = 2'b11,
		RD_DONE  = 2'b10
	} fsc_rd_e;

endpackage

`default_nettype wire

// ### logic/fsc_sticky_flags.sv
// Sticky event flags where a set beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none

module fsc_sticky_flags #(
	parameter int unsigned N = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] setEv,
	input  wire logic [N-1:0] clrEv,
	output logic      [N-1:0] flags
);

	logic [N-1:0] flags_q;

	generate
		if (N < 1)
		begin : g_chk
			$error("fsc_sticky_flags needs at least one flag");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_flag
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					flags_q[i] <= 1'b0;
				else if (setEv[i])
					flags_q[i] <= 1'b1;
				else if (clrEv[i])
					flags_q[i] <= 1'b0;
			end
		end
	endgenerate

	assign flags = flags_q;

endmodule

`default_nettype wire

// ### logic/fsc_protect_mem.sv
// Per-block protection bits with registered read data
`timescale 1ns/1ps
`default_nettype none

module fsc_protect_mem #(
	parameter int unsigned NUM_BLOCKS = 16,
	parameter int unsigned AW         = 4
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic          wdata,
	output logic               rdata
);

	logic [NUM_BLOCKS-1:0] bits_q;
	logic                  rdata_q;

	generate
		if (NUM_BLOCKS > (1 << AW))
		begin : g_chk
			$error("fsc_protect_mem address too narrow");
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bits_q <= '0;
		else if (we && addr < NUM_BLOCKS)
			bits_q[addr] <= wdata;
	end

	// Selects past the last block read zero instead of unknown

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_q <= 1'b0;
		else
			rdata_q <= (addr < NUM_BLOCKS) ? bits_q[addr] : 1'b0;
	end

	assign rdata = rdata_q;

endmodule

`default_nettype wire

// ### logic/fsc_status_config.sv
// Flash status word and configuration readout behind an AHB-Lite slave
//
// How it works
// - Erase retries exhausted sets erase-fail flag
// - Failed block unprotect sets erase-fail flag
// - Fail flags clear only by clear-status or reset
// - Program retries exhausted sets program-fail flag
// - Failed block or device protect sets program-fail
// - Bits two and one give busy bank
// - Bank bits forced zero while ready
// - Wide variant mirrors status into upper half
// - Index zero maker code, one part code
// - Index two returns selected block protection bit
// - Device protect bit blocks protection changes
// - Index four returns mode register contents
// - Index five returns lock disable, reset zero
// - Single-bit reads zero the upper bits
// - Wide variant mirrors configuration into upper half
// - Ready flag high when machine idle
// - Power sequence flag cleared only by reinit or reset
// - Device-level flag with codes marks device cycles
// - Protection violation bit shown beside fail flags
`timescale 1ns/1ps
`default_nettype none

module fsc_status_config #(
	parameter int unsigned DATA_WIDTH    = 16,
	parameter int unsigned NUM_BLOCKS    = 16,
	parameter logic [15:0] MAKER_CODE    = 16'h00a5, // Arbitrary value
	parameter logic [15:0] PART_CODE_X16 = 16'h005a, // Arbitrary value
	parameter logic [15:0] PART_CODE_X32 = 16'h005b  // Arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        wsmBusy,
	input  wire logic [1:0]  wsmBank,
	input  wire logic        wsmDeviceLevel,
	input  wire logic        eraseMaxFail,
	input  wire logic        unprotectFail,
	input  wire logic        programMaxFail,
	input  wire logic        protectFail,
	input  wire logic        protViolation,
	input  wire logic        powerDisrupt,
	input  wire logic        reinitDone,
	output logic             deviceProtect,
	output logic             lockDisable,
	output logic      [15:0] modeSettings
);

	localparam int unsigned BLK_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
	localparam int unsigned HW    = fsc_pkg::HALF_W;

	// ==========================================================
	// Elaboration checks
	generate
		if (DATA_WIDTH != 16 && DATA_WIDTH != 32)
		begin : g_chk_width
			$error("DATA_WIDTH must be 16 or 32");
		end
		if (NUM_BLOCKS < 2 || NUM_BLOCKS > 256)
		begin : g_chk_blocks
			$error("NUM_BLOCKS must lie between 2 and 256");
		end
	endgenerate

	// ==========================================================
	// Bus address phase capture
	fsc_pkg::fsc_rd_e rdState_q;
	fsc_pkg::fsc_rd_e rdState_d;
	logic             accept;
	logic             dpValid_q;
	logic             dpWrite_q;
	logic [9:0]       dpIdx_q;
	logic             wrEn;
	logic             wrCmd;
	logic             wrBlkSel;
	logic             wrMode;

	assign accept = hsel & htrans[1] & hready;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dpValid_q <= 1'b0;
			dpWrite_q <= 1'b0;
			dpIdx_q   <= '0;
		end
		else if (hready)
		begin
			dpValid_q <= accept;
			dpWrite_q <= hwrite;
			dpIdx_q   <= haddr[fsc_pkg::ADDR_LSB +: 10];
		end
	end

	// Writes finish in their data phase without waits
	assign wrEn     = dpValid_q & dpWrite_q & hreadyout;
	assign wrCmd    = wrEn & (dpIdx_q == fsc_pkg::IDX_CMD);
	assign wrBlkSel = wrEn & (dpIdx_q == fsc_pkg::IDX_BLKSEL);
	assign wrMode   = wrEn & (dpIdx_q == fsc_pkg::IDX_MODEWR);

	// ==========================================================
	// Read sequencer: two wait cycles so protection memory settles
	always_comb
	begin
		rdState_d = rdState_q;
		unique case (rdState_q)
			fsc_pkg::RD_IDLE,
			fsc_pkg::RD_DONE:
			begin
				if (accept && !hwrite)
					rdState_d = fsc_pkg::RD_WAIT;
				else
					rdState_d = fsc_pkg::RD_IDLE;
			end
			fsc_pkg::RD_WAIT:
				rdState_d = fsc_pkg::RD_FETCH;
			fsc_pkg::RD_FETCH:
				rdState_d = fsc_pkg::RD_DONE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdState_q <= fsc_pkg::RD_IDLE;
		else
			rdState_q <= rdState_d;
	end

	assign hreadyout = (rdState_q == fsc_pkg::RD_IDLE)
	                || (rdState_q == fsc_pkg::RD_DONE);
	assign hresp     = 1'b0;

	// ==========================================================
	// Software-held control state
	logic             clrStatus;
	logic             blkWrReq;
	logic             blkRefused;
	logic             blkWe;
	logic [BLK_W-1:0] blkSel_q;
	logic             devProt_q;
	logic             lockDis_q;
	logic [15:0]      mode_q;
	logic             blkProtRd;

	assign clrStatus  = wrCmd & hwdata[fsc_pkg::CMD_CLR];
	assign blkWrReq   = wrCmd & hwdata[fsc_pkg::CMD_BLK_WR];
	assign blkRefused = blkWrReq & devProt_q;
	assign blkWe      = blkWrReq & ~devProt_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			blkSel_q <= '0;
		else if (wrBlkSel)
			blkSel_q <= hwdata[BLK_W-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			devProt_q <= fsc_pkg::DEVPROT_RST;
		else if (wrCmd && hwdata[fsc_pkg::CMD_DEV_WR])
			devProt_q <= hwdata[fsc_pkg::CMD_DEV_VAL];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			lockDis_q <= fsc_pkg::LOCKDIS_RST;
		else if (wrCmd && hwdata[fsc_pkg::CMD_LOCK_WR])
			lockDis_q <= hwdata[fsc_pkg::CMD_LOCK_VAL];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mode_q <= fsc_pkg::MODE_RST;
		else if (wrMode)
			mode_q <= hwdata[HW-1:0];
	end

	assign deviceProtect = devProt_q;
	assign lockDisable   = lockDis_q;
	assign modeSettings  = mode_q;

	// ==========================================================
	// Protection bit store
	fsc_protect_mem #(
		.NUM_BLOCKS (NUM_BLOCKS),
		.AW         (BLK_W)
	) u_protect_mem (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (blkWe),
		.addr  (blkSel_q),
		.wdata (hwdata[fsc_pkg::CMD_BLK_VAL]),
		.rdata (blkProtRd)
	);

	// ==========================================================
	// Sticky status flags
	logic [fsc_pkg::NUM_FLAGS-1:0] flagSet;
	logic [fsc_pkg::NUM_FLAGS-1:0] flagClr;
	logic [fsc_pkg::NUM_FLAGS-1:0] flags;

	always_comb
	begin
		flagSet = '0;
		flagClr = '0;
		flagSet[fsc_pkg::FLG_ERASE] = eraseMaxFail | unprotectFail;
		flagSet[fsc_pkg::FLG_PROG]  = programMaxFail | protectFail;
		flagSet[fsc_pkg::FLG_VIOL]  = protViolation | blkRefused;
		flagSet[fsc_pkg::FLG_PWR]   = powerDisrupt;
		flagClr[fsc_pkg::FLG_ERASE] = clrStatus;
		flagClr[fsc_pkg::FLG_PROG]  = clrStatus;
		flagClr[fsc_pkg::FLG_VIOL]  = clrStatus;
		flagClr[fsc_pkg::FLG_PWR]   = reinitDone;
	end

	fsc_sticky_flags #(
		.N (fsc_pkg::NUM_FLAGS)
	) u_flags (
		.clk   (clk),
		.rst_n (rst_n),
		.setEv (flagSet),
		.clrEv (flagClr),
		.flags (flags)
	);

	// ==========================================================
	// Status word assembly
	logic [15:0] status16;

	always_comb
	begin
		status16 = '0;
		status16[fsc_pkg::ST_READY]     = ~wsmBusy;
		status16[fsc_pkg::ST_PWRSEQ]    = flags[fsc_pkg::FLG_PWR];
		status16[fsc_pkg::ST_ERASEFAIL] = flags[fsc_pkg::FLG_ERASE];
		status16[fsc_pkg::ST_PROGFAIL]  = flags[fsc_pkg::FLG_PROG];
		status16[fsc_pkg::ST_PROTVIOL]  = flags[fsc_pkg::FLG_VIOL];
		if (wsmBusy)
		begin
			status16[fsc_pkg::ST_BANK_LO] = wsmBank[1];
			status16[fsc_pkg::ST_BANK_HI] = wsmBank[0];
			status16[fsc_pkg::ST_DEVLVL]  = wsmDeviceLevel;
		end
		// Ready leaves bank and device-level bits at zero
	end

	// ==========================================================
	// Read data selection
	logic [15:0] rdHalf;
	logic        isStatus;
	logic [31:0] rdWord;

	always_comb
	begin
		rdHalf   = '0;
		isStatus = 1'b0;
		unique case (dpIdx_q)
			fsc_pkg::IDX_MAKER:
				rdHalf = MAKER_CODE;
			fsc_pkg::IDX_PART:
				rdHalf = (DATA_WIDTH == 32) ? PART_CODE_X32 : PART_CODE_X16;
			fsc_pkg::IDX_BLKPROT:
				rdHalf[0] = blkProtRd;
			fsc_pkg::IDX_DEVPROT:
				rdHalf[0] = devProt_q;
			fsc_pkg::IDX_MODE:
				rdHalf = mode_q;
			fsc_pkg::IDX_LOCKDIS:
				rdHalf[0] = lockDis_q;
			fsc_pkg::IDX_STATUS:
			begin
				rdHalf   = status16;
				isStatus = 1'b1;
			end
			fsc_pkg::IDX_BLKSEL:
				rdHalf[BLK_W-1:0] = blkSel_q;
			fsc_pkg::IDX_MODEWR:
				rdHalf = mode_q;
			default:
				rdHalf = '0;
		endcase
	end

	always_comb
	begin
		rdWord = {16'h0000, rdHalf};
		if (DATA_WIDTH == 32)
		begin
			rdWord = {rdHalf, rdHalf};
		end
		if (isStatus && DATA_WIDTH == 32)
			rdWord = {status16, status16};
	end

	// ==========================================================
	// Registered read data
	logic [31:0] hrdata_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			hrdata_q <= fsc_pkg::RDATA_RST;
		else if (rdState_q == fsc_pkg::RD_FETCH)
			hrdata_q <= rdWord;
	end

	assign hrdata = hrdata_q;

	// Size is not checked: every transfer is served as a whole word
	logic unusedBits;
	assign unusedBits = ^{hsize, haddr[31:12], haddr[1:0]};

endmodule

`default_nettype wire

// ### tb/fsc_status_config_asserts.sv
// Concurrent checks on the status and configuration readout ports
`timescale 1ns/1ps
`default_nettype none
module fsc_status_config_asserts #(
	parameter int unsigned DATA_WIDTH = 16,
	parameter logic [15:0] MAKER_CODE = 16'h00a5
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        wsmBusy,
	input wire logic        deviceProtect,
	input wire logic        lockDisable,
	input wire logic [15:0] modeSettings
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire       tk = hsel & htrans[1] & hready;
	wire [9:0] ix = haddr[11:2];
	logic      cmdWr_q;
	logic      modeWr_q;
	// ==========================================
	// Data-phase markers of register writes
	always_ff @(posedge clk)
	begin
		cmdWr_q  <= rst_n & tk & hwrite & (ix == fsc_pkg::IDX_CMD);
		modeWr_q <= rst_n & tk & hwrite & (ix == fsc_pkg::IDX_MODEWR);
	end
	// ==========================================
	// Checks
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("response not OKAY");
	read_wait_a: assert property (tk && !hwrite |=> !hreadyout [*2] ##1 hreadyout)
		else $error("read wait states wrong");
	write_ack_a: assert property (tk && hwrite |=> hreadyout)
		else $error("write stalled");
	upper_copy_a: assert property (
		hreadyout |-> hrdata[31:16] ==
		(DATA_WIDTH == 32 ? hrdata[15:0] : 16'h0000))
		else $error("upper half wrong");
	maker_read_a: assert property (
		tk && !hwrite && ix == fsc_pkg::IDX_MAKER
		|-> ##3 hrdata[15:0] == MAKER_CODE)
		else $error("maker code wrong");
	ready_status_a: assert property (
		tk && !hwrite && ix == fsc_pkg::IDX_STATUS
		&& !wsmBusy ##1 !wsmBusy [*2] |=> hrdata[fsc_pkg::ST_READY]
		&& hrdata[2:0] == 3'b000 && hrdata[15:9] == 7'h00 && !hrdata[6])
		else $error("ready status wrong");
	lock_write_a: assert property (
		cmdWr_q && hwdata[fsc_pkg::CMD_LOCK_WR]
		|=> lockDisable == $past(hwdata[fsc_pkg::CMD_LOCK_VAL]))
		else $error("lock disable not written");
	devprot_write_a: assert property (
		cmdWr_q && hwdata[fsc_pkg::CMD_DEV_WR]
		|=> deviceProtect == $past(hwdata[fsc_pkg::CMD_DEV_VAL]))
		else $error("device protect not written");
	mode_write_a: assert property (
		modeWr_q |=> modeSettings == $past(hwdata[15:0]))
		else $error("mode register not written");
	read_c: cover property (tk && !hwrite);
	write_c: cover property (cmdWr_q);
	busy_c: cover property (tk && ix == fsc_pkg::IDX_STATUS && wsmBusy);
endmodule
bind fsc_status_config fsc_status_config_asserts #(
	.DATA_WIDTH(DATA_WIDTH),
	.MAKER_CODE(MAKER_CODE)
) chk (
	.clk(clk),
	.rst_n(rst_n),
	.hsel(hsel),
	.haddr(haddr),
	.htrans(htrans),
	.hwrite(hwrite),
	.hwdata(hwdata),
	.hready(hready),
	.hrdata(hrdata),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.wsmBusy(wsmBusy),
	.deviceProtect(deviceProtect),
	.lockDisable(lockDisable),
	.modeSettings(modeSettings)
);
`default_nettype wire

// ### tb/fsc_ahb_master.sv
// Memory controller model: AHB-Lite single word transfers
`timescale 1ns/1ps
`default_nettype none
module fsc_ahb_master (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial
	begin
		hsel   = 1'b0;
		haddr  = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// Caller enters just after a rising edge
	task automatic xfer(input logic w, input logic [9:0] i,
		input logic [31:0] d, output logic [31:0] r);
	begin
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {20'h0_0000, i, 2'b00};
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		// Released lines stop showing the last value
		haddr  <= ~haddr;
		hwdata <= w ? d : ~hwdata;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		r = hrdata;
		hwdata <= ~hwdata;
	end
	endtask
endmodule
`default_nettype wire

// ### tb/tb_flash_status_and_config_readout.sv
// Self-checking bench for the status and configuration readout
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_and_config_readout;
	localparam int unsigned DW = 32;
	localparam logic [15:0] PART16 = 16'h005a;
	logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic        wsmBusy, wsmDeviceLevel, deviceProtect, lockDisable;
	logic [1:0]  htrans, wsmBank;
	logic [2:0]  hsize;
	logic [6:0]  ev;
	logic [15:0] modeSettings;
	logic [31:0] haddr, hwdata, hrdata, hrdata16, r, x;
	int          bad_count, check_count, seed, i;
	int          sb [6] = '{5, 5, 4, 4, 3, 8};
	assign hready = hreadyout;
	fsc_status_config #(.DATA_WIDTH(DW)) DUT (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .wsmBusy(wsmBusy),
		.wsmBank(wsmBank), .wsmDeviceLevel(wsmDeviceLevel),
		.eraseMaxFail(ev[0]), .unprotectFail(ev[1]), .programMaxFail(ev[2]),
		.protectFail(ev[3]), .protViolation(ev[4]), .powerDisrupt(ev[5]),
		.reinitDone(ev[6]), .deviceProtect(deviceProtect),
		.lockDisable(lockDisable), .modeSettings(modeSettings));
	// Narrow variant on the same bus, answers in lockstep
	fsc_status_config #(.DATA_WIDTH(16)) DUT16 (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata16),
		.hreadyout(), .hresp(), .wsmBusy(wsmBusy),
		.wsmBank(wsmBank), .wsmDeviceLevel(wsmDeviceLevel),
		.eraseMaxFail(ev[0]), .unprotectFail(ev[1]), .programMaxFail(ev[2]),
		.protectFail(ev[3]), .protViolation(ev[4]), .powerDisrupt(ev[5]),
		.reinitDone(ev[6]), .deviceProtect(),
		.lockDisable(), .modeSettings());
	fsc_ahb_master M (.clk(clk), .hready(hready), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] mir(input logic [15:0] v);
		return (DW == 32) ? {v, v} : {16'h0000, v};
	endfunction
	task automatic rd(input logic [9:0] a, input logic [15:0] e, input string s);
		logic [15:0] e16;
		M.xfer(1'b0, a, 32'h0000_0000, r);
		e16 = (a == fsc_pkg::IDX_PART) ? PART16 : e;
		check_count++;
		if (r !== mir(e))
		begin
			$display("[FAIL] %0t %s got %h exp %h", $time, s, r, mir(e));
			bad_count++;
		end
		check_count++;
		if (hrdata16 !== {16'h0000, e16})
		begin
			$display("[FAIL] %0t %s x16 got %h exp %h", $time, s, hrdata16,
				{16'h0000, e16});
			bad_count++;
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		M.xfer(1'b1, a, d, r);
	endtask
	task automatic pulse(input int k);
		ev <= 7'h01 << k;
		@(posedge clk);
		ev <= 7'h00;
		@(posedge clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#20000;
		bad_count++;
		print_verdict;
	end
	initial
	begin
		seed = 55;
		rst_n = 1'b0;
		ev = 7'h00;
		wsmBusy = 1'b0;
		wsmBank = 2'b00;
		wsmDeviceLevel = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(fsc_pkg::IDX_MAKER, 16'h00a5, "maker");
		rd(fsc_pkg::IDX_PART, 16'h005b, "part");
		rd(fsc_pkg::IDX_LOCKDIS, 16'h0000, "lock reset");
		wr(fsc_pkg::IDX_CMD, 32'h0000_0060);
		rd(fsc_pkg::IDX_LOCKDIS, 16'h0001, "lock set");
		rd(10'h3ff, 16'h0000, "unmapped");
		$display("test identity done");
		repeat (4)
		begin
			x = $random(seed);
			wr(fsc_pkg::IDX_MODEWR, x);
			rd(fsc_pkg::IDX_MODE, x[15:0], "mode");
		end
		$display("test mode done");
		repeat (6)
		begin
			x = $random(seed);
			wr(fsc_pkg::IDX_BLKSEL, {28'h000_0000, x[3:0]});
			wr(fsc_pkg::IDX_CMD, {29'h0, x[4], 2'b10});
			rd(fsc_pkg::IDX_BLKPROT, {15'h0, x[4]}, "blk");
		end
		wr(fsc_pkg::IDX_CMD, 32'h0000_0001);
		wr(fsc_pkg::IDX_CMD, 32'h0000_0018);
		rd(fsc_pkg::IDX_DEVPROT, 16'h0001, "devprot");
		wr(fsc_pkg::IDX_CMD, {29'h0, ~x[4], 2'b10});
		rd(fsc_pkg::IDX_BLKPROT, {15'h0, x[4]}, "refused");
		rd(fsc_pkg::IDX_STATUS, 16'h0088, "violation");
		wr(fsc_pkg::IDX_CMD, 32'h0000_0008);
		wr(fsc_pkg::IDX_CMD, {29'h0, ~x[4], 2'b10});
		rd(fsc_pkg::IDX_BLKPROT, {15'h0, ~x[4]}, "allowed");
		$display("test protect done");
		for (i = 0; i < 6; i++)
		begin
			wr(fsc_pkg::IDX_CMD, 32'h0000_0001);
			pulse(i);
			x = 32'h80 | (32'h1 << sb[i]);
			rd(fsc_pkg::IDX_STATUS, x[15:0], "flag");
		end
		wr(fsc_pkg::IDX_CMD, 32'h0000_0001);
		rd(fsc_pkg::IDX_STATUS, 16'h0180, "clear");
		pulse(6);
		rd(fsc_pkg::IDX_STATUS, 16'h0080, "reinit");
		// Events land in the very cycle of the clear write
		fork
			wr(fsc_pkg::IDX_CMD, 32'h0000_0001);
			begin
				@(posedge clk);
				ev <= 7'h61;
				@(posedge clk);
				ev <= 7'h00;
			end
		join
		rd(fsc_pkg::IDX_STATUS, 16'h01a0, "set wins");
		wr(fsc_pkg::IDX_CMD, 32'h0000_0001);
		pulse(6);
		$display("test flags done");
		for (i = 0; i < 8; i++)
		begin
			wsmBusy <= 1'b1;
			wsmBank <= i[1:0];
			wsmDeviceLevel <= i[2];
			@(posedge clk);
			x = {29'h0, i[0], i[1], i[2]};
			rd(fsc_pkg::IDX_STATUS, x[15:0], "busy");
		end
		wsmBusy <= 1'b0;
		@(posedge clk);
		rd(fsc_pkg::IDX_STATUS, 16'h0080, "ready");
		$display("test busy done");
		pulse(0);
		wr(fsc_pkg::IDX_CMD, 32'h0000_0060);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(fsc_pkg::IDX_STATUS, 16'h0080, "after reset");
		rd(fsc_pkg::IDX_LOCKDIS, 16'h0000, "lock after reset");
		$display("test reset done");
		print_verdict;
	end
endmodule
`default_nettype wire
